// [hdl/iwi_top.sv]
// Top of the I/O window decode and interrupt logic
`timescale 1ns/1ns
`default_nettype none
module iwi_top
  import iwi_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [ADDR_W-1:BASE_LSB] base_addr,
  input wire iwi_pkg::iwi_req_type host_req,
  output logic [DATA_W-1:0] rdata_r,
  output logic rhit_r,
  output iwi_pkg::iwi_sc_req_type sc_req,
  input wire logic [DATA_W-1:0] sc_rdata,
  input wire logic sc_irq,
  input wire logic [CNT_W-1:0] tx_free,
  input wire logic [CNT_W-1:0] rx_avail,
  input wire logic fifo_en,
  input wire logic test_irq,
  output logic irq_r,
  output logic sync_a_r,
  output logic sync_a_oe_r,
  output logic [DATA_W-1:0] comm_r,
  output logic [DATA_W-1:0] fifo_ctrl_r,
  output logic [DATA_W-1:0] pat_char_r,
  output logic [DATA_W-1:0] pat_cnt_r,
  output logic [DATA_W-1:0] rx_tmo_r,
  output logic iwi_cmd_ius_r
);
  import iwi_pkg::*;

  function automatic logic at_least(input logic [CNT_W-1:0] cnt);
    at_least = (cnt >= FIFO_THRESH);
  endfunction

  // Reset release through two flops
  logic rst_s1_r;
  logic rst_n_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  // Window decode
  logic hit;
  logic [3:0] ofs;
  logic wr_hit;
  logic rd_hit;
  logic sc_hit;
  assign ofs = host_req.addr[BASE_LSB-1:0];
  assign hit = (host_req.addr[ADDR_W-1:BASE_LSB] == base_addr);
  assign wr_hit = hit && host_req.wr && ce;
  assign rd_hit = hit && host_req.rd && ce;
  assign sc_hit = (ofs[3:2] == 2'b00);

  // Controller ports pass straight through; wr/rd strobes only on a window hit at offsets 0 to 3
  always_comb begin
    sc_req.reg_sel = ofs[1:0];
    sc_req.wdata = host_req.wdata;
    sc_req.wr = wr_hit && sc_hit;
    sc_req.rd = rd_hit && sc_hit;
  end

  // Card register state
  logic [DATA_W-1:0] cfg_r;
  logic [DATA_W-1:0] comm_nxt;
  logic [DATA_W-1:0] cfg_nxt;
  logic [DATA_W-1:0] fifo_ctrl_nxt;
  logic [DATA_W-1:0] pat_char_nxt;
  logic [DATA_W-1:0] pat_cnt_nxt;
  logic [DATA_W-1:0] rx_tmo_nxt;
  logic [DATA_W-1:0] rdata_nxt;
  logic rhit_nxt;
  logic sync_a_nxt;
  logic sync_a_oe_nxt;
  logic cmd_ius_nxt;
  logic [3:0] ist_clr;
  logic ist_mask_wr;
  logic [3:0] ist_status;
  logic [3:0] ist_mask;
  logic [3:0] events;
  logic tx_ok;
  logic rx_ok;
  logic irq_int;
  iwi_src_type src_sel;

  assign tx_ok = at_least(tx_free);
  assign rx_ok = at_least(rx_avail);
  assign src_sel = iwi_src_type'(cfg_r[CFG_SEL_LSB +: 2]);

  always_comb begin
    events = 4'h0;
    events[IST_SC_BIT] = sc_irq;
    events[IST_TX_BIT] = fifo_en && tx_ok;
    events[IST_RX_BIT] = fifo_en && rx_ok;
    events[IST_TEST_BIT] = test_irq;
  end

  // Register writes
  always_comb begin
    comm_nxt = comm_r;
    cfg_nxt = cfg_r;
    fifo_ctrl_nxt = fifo_ctrl_r;
    pat_char_nxt = pat_char_r;
    pat_cnt_nxt = pat_cnt_r;
    rx_tmo_nxt = rx_tmo_r;
    ist_clr = 4'h0;
    ist_mask_wr = 1'b0;
    cmd_ius_nxt = 1'b0;
    if (wr_hit) begin
      unique case (ofs)
        OFS_CHA_CTRL, OFS_CHB_CTRL: begin
          cmd_ius_nxt = (host_req.wdata == CMD_RESET_IUS);
        end
        OFS_COMM: comm_nxt = host_req.wdata;
        OFS_CONFIG: cfg_nxt = host_req.wdata;
        OFS_INT_STAT: begin
          ist_clr = host_req.wdata[3:0];
          ist_mask_wr = 1'b1;
        end
        OFS_FIFO_CTRL: fifo_ctrl_nxt = host_req.wdata;
        OFS_PAT_CHAR: pat_char_nxt = host_req.wdata;
        OFS_PAT_CNT: pat_cnt_nxt = host_req.wdata;
        OFS_RX_TMO: rx_tmo_nxt = host_req.wdata;
        default: cmd_ius_nxt = 1'b0;
      endcase
    end
  end

  // Read data, one cycle after the strobe
  always_comb begin
    rdata_nxt = rdata_r;
    rhit_nxt = rd_hit;
    if (rd_hit) begin
      unique case (ofs)
        OFS_CHA_DATA, OFS_CHA_CTRL, OFS_CHB_DATA, OFS_CHB_CTRL:
          rdata_nxt = sc_rdata;
        OFS_COMM: rdata_nxt = comm_r;
        OFS_CONFIG: rdata_nxt = cfg_r;
        OFS_INT_STAT: rdata_nxt = {ist_mask, ist_status};
        OFS_FIFO_STAT: begin
          rdata_nxt = 8'h00;
          rdata_nxt[FST_TX_BIT] = tx_ok;
          rdata_nxt[FST_RX_BIT] = rx_ok;
        end
        OFS_FIFO_CTRL: rdata_nxt = fifo_ctrl_r;
        OFS_PAT_CHAR: rdata_nxt = pat_char_r;
        OFS_PAT_CNT: rdata_nxt = pat_cnt_r;
        OFS_RX_TMO: rdata_nxt = rx_tmo_r;
        default: rdata_nxt = RSV_READ;
      endcase
    end
  end

  // Channel A alignment input control
  always_comb begin
    sync_a_oe_nxt = cfg_r[CFG_SYNC_CTL_BIT];
    sync_a_nxt = cfg_r[CFG_SYNC_CTL_BIT] && comm_r[COMM_RLB_BIT];
  end

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      comm_r <= RST_REG;
      cfg_r <= RST_REG;
      fifo_ctrl_r <= RST_REG;
      pat_char_r <= RST_REG;
      pat_cnt_r <= RST_REG;
      rx_tmo_r <= RST_REG;
      rdata_r <= RST_REG;
      rhit_r <= 1'b0;
      sync_a_r <= 1'b0;
      sync_a_oe_r <= 1'b0;
      iwi_cmd_ius_r <= 1'b0;
      irq_r <= 1'b0;
    end else if (ce) begin
      comm_r <= comm_nxt;
      cfg_r <= cfg_nxt;
      fifo_ctrl_r <= fifo_ctrl_nxt;
      pat_char_r <= pat_char_nxt;
      pat_cnt_r <= pat_cnt_nxt;
      rx_tmo_r <= rx_tmo_nxt;
      rdata_r <= rdata_nxt;
      rhit_r <= rhit_nxt;
      sync_a_r <= sync_a_nxt;
      sync_a_oe_r <= sync_a_oe_nxt;
      iwi_cmd_ius_r <= cmd_ius_nxt;
      irq_r <= irq_int;
    end
  end

  iwi_irq u_irq (
    .clk(clk),
    .rst_n(rst_n_r),
    .ce(ce),
    .events(events),
    .clr(ist_clr),
    .mask_wr_val(host_req.wdata[IST_MASK_LSB +: 4]),
    .mask_wr(ist_mask_wr),
    .src_sel(src_sel),
    .status_r(ist_status),
    .mask_r(ist_mask),
    .irq_r(irq_int)
  );
endmodule
`default_nettype wire

// [hdl/iwi_pkg.sv]
// Package of constants and types for the I/O window interrupt logic
package iwi_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int BASE_LSB = 4;
  localparam int CNT_W = 12;
  // Window offsets
  localparam logic [3:0] OFS_CHA_DATA = 4'h0;
  localparam logic [3:0] OFS_CHA_CTRL = 4'h1;
  localparam logic [3:0] OFS_CHB_DATA = 4'h2;
  localparam logic [3:0] OFS_CHB_CTRL = 4'h3;
  localparam logic [3:0] OFS_COMM = 4'h4;
  localparam logic [3:0] OFS_CONFIG = 4'h5;
  localparam logic [3:0] OFS_RSV0 = 4'h6;
  localparam logic [3:0] OFS_RSV1 = 4'h7;
  localparam logic [3:0] OFS_INT_STAT = 4'h8;
  localparam logic [3:0] OFS_FIFO_STAT = 4'h9;
  localparam logic [3:0] OFS_FIFO_CTRL = 4'hA;
  localparam logic [3:0] OFS_PAT_CHAR = 4'hB;
  localparam logic [3:0] OFS_PAT_CNT = 4'hC;
  localparam logic [3:0] OFS_RX_TMO = 4'hD;
  localparam logic [3:0] OFS_RSV2 = 4'hE;
  localparam logic [3:0] OFS_RSV3 = 4'hF;
  // Field positions
  localparam int COMM_RLB_BIT = 0;
  localparam int CFG_SYNC_CTL_BIT = 0;
  localparam int CFG_SEL_LSB = 4;
  localparam int IST_SC_BIT = 0;
  localparam int IST_TX_BIT = 1;
  localparam int IST_RX_BIT = 2;
  localparam int IST_TEST_BIT = 3;
  localparam int IST_MASK_LSB = 4;
  localparam int FST_TX_BIT = 0;
  localparam int FST_RX_BIT = 1;
  // Reset and fixed values
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [3:0] RST_MASK = 4'hF;
  localparam logic [7:0] RSV_READ = 8'hFF;
  localparam logic [7:0] CMD_RESET_IUS = 8'h38;
  // FIFO service threshold in bytes, shared by TX and RX
  localparam logic [CNT_W-1:0] FIFO_THRESH = 12'h200;
  // Interrupt source selection
  typedef enum logic [1:0] {
    SRC_SC = 2'b00,
    SRC_FIFO = 2'b01,
    SRC_TEST = 2'b11,
    SRC_NONE = 2'b10
  } iwi_src_type;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } iwi_req_type;
  typedef struct packed {
    logic [1:0] reg_sel;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } iwi_sc_req_type;
endpackage

// [hdl/iwi_irq.sv]
// Interrupt status, mask and source selection of the I/O window
`timescale 1ns/1ns
`default_nettype none
module iwi_irq
  import iwi_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [3:0] events,
  input wire logic [3:0] clr,
  input wire logic [3:0] mask_wr_val,
  input wire logic mask_wr,
  input wire iwi_pkg::iwi_src_type src_sel,
  output logic [3:0] status_r,
  output logic [3:0] mask_r,
  output logic irq_r
);
  logic [3:0] status_nxt;
  logic [3:0] mask_nxt;
  logic irq_nxt;
  logic [3:0] sel_bits;

  always_comb begin
    // Sticky bits; a new event wins over a clear
    status_nxt = (status_r & ~clr) | events;
    mask_nxt = mask_wr ? mask_wr_val : mask_r;
    unique case (src_sel)
      SRC_SC: sel_bits = 4'h1 << IST_SC_BIT;
      SRC_FIFO: sel_bits = (4'h1 << IST_TX_BIT) | (4'h1 << IST_RX_BIT);
      SRC_TEST: sel_bits = 4'h1 << IST_TEST_BIT;
      SRC_NONE: sel_bits = 4'h0;
    endcase
    // Held while any selected unserviced bit with its mask_r bit set stands
    irq_nxt = |(status_r & mask_r & sel_bits);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_r <= 4'h0;
      mask_r <= RST_MASK;
      irq_r <= 1'b0;
    end else if (ce) begin
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      irq_r <= irq_nxt;
    end
  end
endmodule
`default_nettype wire

// [test/iwi_top_asserts.sv]
// Checker of the I/O window decode, register and alignment logic
`timescale 1ns/1ns
`default_nettype none
module iwi_chk
  import iwi_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [ADDR_W-1:BASE_LSB] base_addr,
  input wire iwi_pkg::iwi_req_type host_req,
  input wire logic [DATA_W-1:0] rdata_r,
  input wire logic rhit_r,
  input wire iwi_pkg::iwi_sc_req_type sc_req,
  input wire logic sync_a_r,
  input wire logic sync_a_oe_r,
  input wire logic [DATA_W-1:0] comm_r,
  input wire logic iwi_cmd_ius_r
);
  logic hit;
  logic sc;
  logic [3:0] ofs;
  assign ofs = host_req.addr[3:0];
  assign hit = host_req.addr[9:4] == base_addr;
  assign sc = hit && ofs[3:2] == 2'b00;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  read_hit_a: assert property (host_req.rd && hit |=> rhit_r)
    else $error("read hit lost");
  read_miss_a: assert property (host_req.rd && !hit |=> !rhit_r)
    else $error("read miss answered");
  sc_read_a: assert property (host_req.rd && sc |-> sc_req.rd
    && sc_req.reg_sel == ofs[1:0]) else $error("controller read lost");
  sc_write_a: assert property (host_req.wr && sc |-> sc_req.wr
    && sc_req.wdata == host_req.wdata) else $error("controller write lost");
  sc_block_a: assert property (ofs[3:2] != 2'b00 |-> !sc_req.wr
    && !sc_req.rd) else $error("controller strobe leak");
  rsv_read_a: assert property (host_req.rd && hit && ofs[2:1] == 2'b11
    |=> rdata_r == RSV_READ) else $error("reserved read value");
  cmd_pulse_a: assert property (host_req.wr && sc && ofs[0]
    && host_req.wdata == CMD_RESET_IUS |=> iwi_cmd_ius_r)
    else $error("command pulse lost");
  comm_store_a: assert property (host_req.wr && hit && ofs == OFS_COMM
    |=> comm_r == $past(host_req.wdata)) else $error("comm not stored");
  sync_drive_a: assert property (sync_a_r |-> sync_a_oe_r
    && $past(comm_r[COMM_RLB_BIT])) else $error("alignment drive wrong");
endmodule
bind iwi_top iwi_chk u_chk (.clk(clk), .rstn(rstn), .base_addr(base_addr),
  .host_req(host_req), .rdata_r(rdata_r), .rhit_r(rhit_r),
  .sc_req(sc_req), .sync_a_r(sync_a_r), .sync_a_oe_r(sync_a_oe_r),
  .comm_r(comm_r), .iwi_cmd_ius_r(iwi_cmd_ius_r));
`default_nettype wire

// [test/iwi_sc_model.sv]
// Serial controller model on the far side of the window
`timescale 1ns/1ns
`default_nettype none
module iwi_sc_model
  import iwi_pkg::*;
#(
  parameter logic [7:0] VEC = 8'h5A
)
(
  input wire logic clk,
  input wire iwi_pkg::iwi_sc_req_type sc_req,
  output logic [DATA_W-1:0] sc_rdata,
  output logic [DATA_W-1:0] last_cmd
);
  logic [DATA_W-1:0] pat_r = 8'h00;
  initial last_cmd = 8'h00;
  always @(posedge clk) begin
    pat_r <= pat_r + 8'h01;
    if (sc_req.wr && sc_req.reg_sel[0]) begin
      last_cmd <= sc_req.wdata;
    end
  end
  always_comb begin
    sc_rdata = pat_r;
    if (sc_req.rd) begin
      sc_rdata = (sc_req.reg_sel == 2'h3) ? VEC : {6'h00, sc_req.reg_sel};
    end
  end
endmodule
`default_nettype wire

// [test/iwi_top_tb_top.sv]
// Testbench of the I/O window decode and interrupt logic
`timescale 1ns/1ns
`default_nettype none
module iwi_top_tb_top;
  import iwi_pkg::*;
  localparam logic [5:0] BASE = 6'h30;
  localparam logic [7:0] VEC = 8'h5A;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic sc_irq = 1'b0;
  logic fifo_en = 1'b0;
  logic test_irq = 1'b0;
  logic [CNT_W-1:0] tx_free = 12'h000;
  logic [CNT_W-1:0] rx_avail = 12'h000;
  iwi_req_type hreq = '0;
  iwi_sc_req_type sc_req;
  logic [7:0] rdata, sc_rdata, last_cmd, d;
  logic rhit, irq, sync_a, sync_oe;
  logic [7:0] comm, fctl, pchr, pcnt, rtmo;
  logic cmd_ius;
  int fail_count = 0;
  int comparisons = 0;
  always #5 clk = ~clk;
  iwi_top uut (.clk(clk), .rstn(rstn), .ce(1'b1), .base_addr(BASE),
    .host_req(hreq), .rdata_r(rdata), .rhit_r(rhit), .sc_req(sc_req),
    .sc_rdata(sc_rdata), .sc_irq(sc_irq), .tx_free(tx_free),
    .rx_avail(rx_avail), .fifo_en(fifo_en), .test_irq(test_irq),
    .irq_r(irq), .sync_a_r(sync_a), .sync_a_oe_r(sync_oe), .comm_r(comm),
    .fifo_ctrl_r(fctl), .pat_char_r(pchr), .pat_cnt_r(pcnt),
    .rx_tmo_r(rtmo), .iwi_cmd_ius_r(cmd_ius));
  iwi_sc_model #(.VEC(VEC)) sc (.clk(clk), .sc_req(sc_req),
    .sc_rdata(sc_rdata), .last_cmd(last_cmd));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task finish_test;
    $display("mismatches=%0d comparisons=%0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk) hreq <= {BASE, a, v, 2'b10};
    @(posedge clk) hreq.wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [5:0] b, output logic h);
    @(posedge clk) hreq <= {b, a, 8'h00, 2'b01};
    @(posedge clk) hreq.rd <= 1'b0;
    #1 d = rdata;
    h = rhit;
  endtask
  task rdc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    logic h;
    rd(a, BASE, h);
    chk({7'h00, h}, 8'h01);
    chk(d & m, e);
  endtask
  task wait_irq(input logic e);
    int n;
    n = 0;
    #1;
    while (irq !== e && n < 8) begin
      @(posedge clk);
      #1 n++;
    end
    chk({7'h00, irq}, {7'h00, e});
  endtask
  task clr_all;
    repeat (3) @(posedge clk);
    wr(OFS_INT_STAT, 8'hFF);
  endtask
  task t_map;
    logic h;
    for (int i = 4; i < 16; i++) begin
      if (i == 8 || i == 9) continue;
      wr(i[3:0], 8'hC0 + 8'(i));
      rdc(i[3:0], 8'hFF, i[2:1] == 2'b11 ? 8'hFF : 8'hC0 + 8'(i));
    end
    chk(comm, 8'hC4);
    chk(fctl, 8'hCA);
    chk(pchr, 8'hCB);
    chk(pcnt, 8'hCC);
    chk(rtmo, 8'hCD);
    rd(4'h4, BASE + 6'h01, h);
    chk({7'h00, h}, 8'h00);
    chk(d, 8'hFF);
  endtask
  task t_sc;
    rdc(OFS_CHB_CTRL, 8'hFF, VEC);
    rdc(OFS_CHA_CTRL, 8'hFF, 8'h01);
    wr(OFS_CHA_CTRL, CMD_RESET_IUS);
    #1 chk(last_cmd, CMD_RESET_IUS);
    chk({7'h00, cmd_ius}, 8'h01);
    #10 chk({7'h00, cmd_ius}, 8'h00);
  endtask
  task t_sync;
    wr(OFS_CONFIG, 8'h01);
    wr(OFS_COMM, 8'h01);
    #15 chk({6'h00, sync_oe, sync_a}, 8'h03);
    wr(OFS_COMM, 8'h00);
    #15 chk({6'h00, sync_oe, sync_a}, 8'h02);
  endtask
  task t_irq;
    wr(OFS_CONFIG, 8'h00);
    wr(OFS_INT_STAT, 8'hFF);
    sc_irq <= 1'b1;
    wait_irq(1'b1);
    wr(OFS_INT_STAT, 8'hF1);
    #15 chk({7'h00, irq}, 8'h01);
    rdc(OFS_INT_STAT, 8'hFF, 8'hF1);
    @(posedge clk) sc_irq <= 1'b0;
    clr_all;
    wait_irq(1'b0);
    wr(OFS_INT_STAT, 8'h0F);
    sc_irq <= 1'b1;
    repeat (6) @(posedge clk);
    #1 chk({7'h00, irq}, 8'h00);
    @(posedge clk) sc_irq <= 1'b0;
    clr_all;
    wait_irq(1'b0);
  endtask
  task t_fifo;
    wr(OFS_CONFIG, 8'h10);
    fifo_en <= 1'b1;
    rx_avail <= 12'h200;
    tx_free <= 12'h1FF;
    rdc(OFS_FIFO_STAT, 8'h03, 8'h02);
    wait_irq(1'b1);
    rdc(OFS_INT_STAT, 8'h0F, 8'h04);
    @(posedge clk) rx_avail <= 12'h1FF;
    clr_all;
    wait_irq(1'b0);
    rdc(OFS_FIFO_STAT, 8'h03, 8'h00);
    @(posedge clk) tx_free <= 12'h200;
    wait_irq(1'b1);
    rdc(OFS_FIFO_STAT, 8'h03, 8'h01);
    @(posedge clk) tx_free <= 12'h000;
    clr_all;
  endtask
  task t_test;
    wr(OFS_CONFIG, 8'h30);
    test_irq <= 1'b1;
    wait_irq(1'b1);
    wr(OFS_CONFIG, 8'h20);
    wait_irq(1'b0);
    @(posedge clk) test_irq <= 1'b0;
    clr_all;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    t_map;
    t_sc;
    t_sync;
    t_irq;
    t_fifo;
    t_test;
    finish_test;
  end
  initial begin
    #100000;
    fail_count++;
    finish_test;
  end
endmodule
`default_nettype wire
